// File: sleep_gate_pkg.sv
// constants of the sleep clock gating bank: offsets, layouts, reset values
// assumes one 50 MHz system clock and a byte-addressed register port
package sleep_gate_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SLEEP_GATE = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_GATE_CFG = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_FAULT_STS = 12'h204;
  localparam logic [ADDR_W-1:0] OFF_FAULT_MASK = 12'h208;
  localparam logic [ADDR_W-1:0] OFF_CLK_STATE = 12'h20C;

  // unit bit positions inside every 32-bit gate vector
  localparam int BIT_GP_GATE_A = 19;
  localparam int BIT_GP_GATE_B = 18;
  localparam int BIT_GP_GATE_C = 17;
  localparam int BIT_GP_GATE_D = 16;
  localparam int BIT_TWO_WIRE_UNIT1 = 14;
  localparam int BIT_TWO_WIRE_UNIT0 = 12;
  localparam int BIT_SYNC_SERIAL_UNIT1 = 5;
  localparam int BIT_SYNC_SERIAL_UNIT0 = 4;
  localparam int BIT_ASYNC_SERIAL_UNIT2 = 2;
  localparam int BIT_ASYNC_SERIAL_UNIT1 = 1;
  localparam int BIT_ASYNC_SERIAL_UNIT0 = 0;

  // writable bits: 19:16, 14, 12, 5:4, 2:0
  localparam logic [DATA_W-1:0] UNIT_MASK = 32'h000F5037;

  // configuration register field
  localparam int BIT_AUTO_CLOCK_GATING = 0;

  // reset values
  localparam logic [DATA_W-1:0] RST_SLEEP_GATE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_FAULT_MASK = 32'h00000000;
  localparam logic RST_AUTO_CLOCK_GATING = 1'b0;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_DEEP
  } power_mode_t;

endpackage

// File: sleep_clock_gating_bank.sv
// sleep clock gating bank: gate register, unit clock enables, bus faults
// assumes mode and access inputs come from logic on sys_clk (no sync)
`timescale 1ns/1ps

module sleep_clock_gating_bank
  import sleep_gate_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // power mode from the system controller
  input wire logic mode_sleep,
  input wire logic mode_deep,
  // gate vectors of the run and deep-sleep registers
  input wire logic [DATA_W-1:0] run_clock_gate_ctrl_1,
  input wire logic [DATA_W-1:0] deepsleep_clock_gate_ctrl_1,
  // unit access requests and answers
  input wire logic [DATA_W-1:0] periph_req,
  output logic [DATA_W-1:0] periph_ack,
  output logic [DATA_W-1:0] periph_fault,
  // unit clock enables
  output logic [DATA_W-1:0] unit_clk_en,
  // interrupt
  output logic irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // state
  logic [DATA_W-1:0] sleep_gate_r;
  logic [DATA_W-1:0] sleep_gate_nxt;
  logic acg_r;
  logic acg_nxt;
  logic [DATA_W-1:0] fault_sts_r;
  logic [DATA_W-1:0] fault_sts_nxt;
  logic [DATA_W-1:0] fault_mask_r;
  logic [DATA_W-1:0] fault_mask_nxt;
  logic [DATA_W-1:0] clk_en_r;
  logic [DATA_W-1:0] clk_en_nxt;
  logic [DATA_W-1:0] ack_r;
  logic [DATA_W-1:0] ack_nxt;
  logic [DATA_W-1:0] fault_r;
  logic [DATA_W-1:0] fault_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  // decode
  wire logic wr_sleep_gate = reg_wr && hit(reg_addr, OFF_SLEEP_GATE);
  wire logic wr_gate_cfg = reg_wr && hit(reg_addr, OFF_GATE_CFG);
  wire logic wr_fault_mask = reg_wr && hit(reg_addr, OFF_FAULT_MASK);
  wire logic rd_fault_sts = reg_rd && hit(reg_addr, OFF_FAULT_STS);

  // power mode selection
  power_mode_t mode;
  assign mode = mode_deep ? PM_DEEP : (mode_sleep ? PM_SLEEP : PM_RUN);

  // reserved bits never store a one
  assign sleep_gate_nxt = wr_sleep_gate ?
                          (reg_wdata & UNIT_MASK) :
                          sleep_gate_r;
  assign acg_nxt = wr_gate_cfg ? reg_wdata[BIT_AUTO_CLOCK_GATING] : acg_r;
  assign fault_mask_nxt = wr_fault_mask ? (reg_wdata & UNIT_MASK) :
                          fault_mask_r;

  // named unit fields of the sleep register
  wire logic gp_gate_a = sleep_gate_r[BIT_GP_GATE_A];
  wire logic gp_gate_b = sleep_gate_r[BIT_GP_GATE_B];
  wire logic gp_gate_c = sleep_gate_r[BIT_GP_GATE_C];
  wire logic gp_gate_d = sleep_gate_r[BIT_GP_GATE_D];
  wire logic two_wire_unit1_gate = sleep_gate_r[BIT_TWO_WIRE_UNIT1];
  wire logic two_wire_unit0_gate = sleep_gate_r[BIT_TWO_WIRE_UNIT0];
  wire logic sync_serial_unit1_gate =
    sleep_gate_r[BIT_SYNC_SERIAL_UNIT1];
  wire logic sync_serial_unit0_gate =
    sleep_gate_r[BIT_SYNC_SERIAL_UNIT0];
  wire logic async_serial_unit2_gate =
    sleep_gate_r[BIT_ASYNC_SERIAL_UNIT2];
  wire logic async_serial_unit1_gate =
    sleep_gate_r[BIT_ASYNC_SERIAL_UNIT1];
  wire logic async_serial_unit0_gate =
    sleep_gate_r[BIT_ASYNC_SERIAL_UNIT0];

  // word rebuilt from its fields, so a reserved bit can never leak out
  logic [DATA_W-1:0] sleep_gate_view;
  always_comb
  begin
    sleep_gate_view = '0;
    sleep_gate_view[BIT_GP_GATE_A] = gp_gate_a;
    sleep_gate_view[BIT_GP_GATE_B] = gp_gate_b;
    sleep_gate_view[BIT_GP_GATE_C] = gp_gate_c;
    sleep_gate_view[BIT_GP_GATE_D] = gp_gate_d;
    sleep_gate_view[BIT_TWO_WIRE_UNIT1] = two_wire_unit1_gate;
    sleep_gate_view[BIT_TWO_WIRE_UNIT0] = two_wire_unit0_gate;
    sleep_gate_view[BIT_SYNC_SERIAL_UNIT1] = sync_serial_unit1_gate;
    sleep_gate_view[BIT_SYNC_SERIAL_UNIT0] = sync_serial_unit0_gate;
    sleep_gate_view[BIT_ASYNC_SERIAL_UNIT2] = async_serial_unit2_gate;
    sleep_gate_view[BIT_ASYNC_SERIAL_UNIT1] = async_serial_unit1_gate;
    sleep_gate_view[BIT_ASYNC_SERIAL_UNIT0] = async_serial_unit0_gate;
  end

  // the sleep vector is used only in Sleep with auto gating on;
  // without auto gating the run vector also holds during sleep modes
  logic [DATA_W-1:0] gate_sel;
  always_comb
  begin
    gate_sel = run_clock_gate_ctrl_1;
    unique case (mode)
      PM_RUN:
      begin
        gate_sel = run_clock_gate_ctrl_1;
      end
      PM_SLEEP:
      begin
        if (acg_r)
        begin
          gate_sel = sleep_gate_view;
        end
      end
      PM_DEEP:
      begin
        if (acg_r)
        begin
          gate_sel = deepsleep_clock_gate_ctrl_1;
        end
      end
    endcase
  end

  // one enable per unit; timers, two-wire, sync and async serial units
  genvar g;
  generate
    for (g = 0; g < DATA_W; g = g + 1)
    begin : gen_unit
      if (UNIT_MASK[g])
      begin : gen_live
        assign clk_en_nxt[g] = gate_sel[g];
      end
      else
      begin : gen_none
        assign clk_en_nxt[g] = 1'b0;
      end
    end
  endgenerate

  // a request is judged against the clock the unit has right now
  wire logic [DATA_W-1:0] req_live = periph_req & UNIT_MASK;
  assign ack_nxt = req_live & clk_en_r;
  assign fault_nxt = req_live & ~clk_en_r;

  // sticky fault status; a new fault wins over the read clear
  assign fault_sts_nxt = (rd_fault_sts ? '0 : fault_sts_r) | fault_nxt;
  assign irq_nxt = |(fault_sts_nxt & fault_mask_nxt);

  // read mux; data only in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (hit(reg_addr, OFF_SLEEP_GATE))
    begin
      rd_mux = sleep_gate_view;
    end
    else if (hit(reg_addr, OFF_GATE_CFG))
    begin
      rd_mux[BIT_AUTO_CLOCK_GATING] = acg_r;
    end
    else if (hit(reg_addr, OFF_FAULT_STS))
    begin
      rd_mux = fault_sts_r;
    end
    else if (hit(reg_addr, OFF_FAULT_MASK))
    begin
      rd_mux = fault_mask_r;
    end
    else if (hit(reg_addr, OFF_CLK_STATE))
    begin
      rd_mux = clk_en_r;
    end
  end
  assign rdata_nxt = reg_rd ? rd_mux : '0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sleep_gate_r <= RST_SLEEP_GATE;
    end
    else
    begin
      sleep_gate_r <= sleep_gate_nxt;
    end
  end

  // off after reset, so the run vector rules until software opts in
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      acg_r <= RST_AUTO_CLOCK_GATING;
    end
    else
    begin
      acg_r <= acg_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fault_mask_r <= RST_FAULT_MASK;
    end
    else
    begin
      fault_mask_r <= fault_mask_nxt;
    end
  end

  // enables lag the mode and the vectors by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clk_en_r <= '0;
    end
    else
    begin
      clk_en_r <= clk_en_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_r <= '0;
    end
    else
    begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fault_r <= '0;
    end
    else
    begin
      fault_r <= fault_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fault_sts_r <= '0;
    end
    else
    begin
      fault_sts_r <= fault_sts_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign periph_ack = ack_r;
  assign periph_fault = fault_r;
  assign unit_clk_en = clk_en_r;
  assign irq = irq_r;

endmodule // sleep_clock_gating_bank

// File: gate_chk_props.sv
// port checker for the sleep clock gating bank
// assumes one clock domain with a synchronous reset
`timescale 1ns/1ps
module gate_chk
  import sleep_gate_pkg::*;
(
  // clock, reset, strobes
  input wire logic sys_clk, rst, reg_rd, reg_wr, mode_sleep, mode_deep, irq,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_rdata, run_clock_gate_ctrl_1,
  // unit side
  input wire logic [DATA_W-1:0] periph_req, periph_ack, periph_fault,
  input wire logic [DATA_W-1:0] unit_clk_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack;
    |periph_req |=> periph_ack == $past(periph_req & unit_clk_en & UNIT_MASK);
  endproperty
  property p_fault;
    |periph_req |=>
      periph_fault == $past(periph_req & ~unit_clk_en & UNIT_MASK);
  endproperty
  property p_excl;
    (periph_ack & periph_fault) == '0;
  endproperty
  property p_rsv;
    (unit_clk_en & ~UNIT_MASK) == '0;
  endproperty
  property p_rsvrd;
    reg_rd && reg_addr == OFF_SLEEP_GATE |=> (reg_rdata & ~UNIT_MASK) == '0;
  endproperty
  property p_run;
    !mode_sleep && !mode_deep |=>
      unit_clk_en == $past(run_clock_gate_ctrl_1 & UNIT_MASK);
  endproperty
  // irq may also rise when a mask bit meets a sticky status bit
  property p_irq;
    $rose(irq) |-> |periph_fault || $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  property p_clkst;
    reg_rd && reg_addr == OFF_CLK_STATE |=> reg_rdata == $past(unit_clk_en);
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong");
  a_fault: assert property (p_fault) else $error("fault wrong");
  a_excl: assert property (p_excl) else $error("ack with fault");
  a_rsv: assert property (p_rsv) else $error("reserved enable");
  a_rsvrd: assert property (p_rsvrd) else $error("reserved read");
  a_run: assert property (p_run) else $error("run vector");
  a_irq: assert property (p_irq) else $error("irq cause");
  a_clkst: assert property (p_clkst) else $error("state read");
  c_fault: cover property (|periph_fault);
  c_ack: cover property (|periph_ack);
  c_irq: cover property (irq);
endmodule // gate_chk

bind sleep_clock_gating_bank gate_chk i_chk (.sys_clk, .rst, .reg_rd,
  .reg_wr, .mode_sleep, .mode_deep, .irq, .reg_addr, .reg_rdata,
  .run_clock_gate_ctrl_1, .periph_req, .periph_ack, .periph_fault,
  .unit_clk_en);

// File: tb_top.sv
// testbench of the sleep clock gating bank
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module tb_top
  import sleep_gate_pkg::*;
;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic mode_sleep = 0, mode_deep = 0, irq;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, unit_clk_en;
  logic [DATA_W-1:0] run_clock_gate_ctrl_1 = '0;
  logic [DATA_W-1:0] deepsleep_clock_gate_ctrl_1 = '0;
  logic [DATA_W-1:0] periph_req = '0, periph_ack, periph_fault;
  int error_cnt = 0, check_count = 0, cyc = 0;
  sleep_clock_gating_bank i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mode_sleep, .mode_deep,
    .run_clock_gate_ctrl_1, .deepsleep_clock_gate_ctrl_1, .periph_req,
    .periph_ack, .periph_fault, .unit_clk_en, .irq);
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic req(input logic [31:0] r, ea, ef);
    @(posedge sys_clk);
    periph_req <= r;
    @(posedge sys_clk);
    periph_req <= '0;
    #1 chk(periph_ack, ea);
    chk(periph_fault, ef);
  endtask
  // hang guard, far above the roughly 175 cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_SLEEP_GATE, RST_SLEEP_GATE);
    rd(OFF_FAULT_MASK, RST_FAULT_MASK);
    rd(OFF_GATE_CFG, 32'h00000000);
    wr(OFF_SLEEP_GATE, 32'hFFFFFFFF);
    rd(OFF_SLEEP_GATE, UNIT_MASK);
    wr(12'h300, 32'hFFFFFFFF);
    rd(12'h300, 32'h00000000);
    for (int i = 0; i < 32; i++)
    begin
      wr(OFF_SLEEP_GATE, 32'h1 << i);
      rd(OFF_SLEEP_GATE, (32'h1 << i) & UNIT_MASK);
    end
    wr(OFF_SLEEP_GATE, UNIT_MASK);
    rd(OFF_CLK_STATE, 32'h00000000);
    mode_sleep <= 1'b1;
    rd(OFF_CLK_STATE, 32'h00000000);
    wr(OFF_GATE_CFG, 32'h00000001);
    rd(OFF_CLK_STATE, UNIT_MASK);
    chk(unit_clk_en, UNIT_MASK);
    deepsleep_clock_gate_ctrl_1 <= 32'hFFF00010;
    mode_deep <= 1'b1;
    rd(OFF_CLK_STATE, 32'h00000010);
    chk(unit_clk_en, 32'h00000010);
    mode_deep <= 1'b0;
    mode_sleep <= 1'b0;
    run_clock_gate_ctrl_1 <= 32'h00000001;
    req(32'h80000002, 32'h0, 32'h2);
    chk(irq, 1'b0);
    wr(OFF_FAULT_MASK, UNIT_MASK);
    @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    rd(OFF_FAULT_STS, 32'h2);
    @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    req(32'h80000003, 32'h1, 32'h2);
    chk(irq, 1'b1);
    // a fault in the read-clear cycle must stay set
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= OFF_FAULT_STS;
    periph_req <= 32'h00000002;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    periph_req <= '0;
    #1 chk(reg_rdata, 32'h00000002);
    chk(periph_fault, 32'h00000002);
    rd(OFF_FAULT_STS, 32'h00000002);
    rd(OFF_FAULT_STS, 32'h00000000);
    chk(irq, 1'b0);
    print_verdict();
  end
endmodule // tb_top
